//--- cfc_params.svh
`ifndef CFC_PARAMS_SVH
`define CFC_PARAMS_SVH

// Register index of the filter control word
`define CFC_OFS_CONTROL 4'h0
// Register index of the read-only status word
`define CFC_OFS_STATUS 4'h1
// Field positions inside one byte slot
`define CFC_BIT_ON 7
`define CFC_MASK_HI 6
`define CFC_MASK_LO 5
`define CFC_FIFO_HI 4
`define CFC_FIFO_LO 0
// Reset value of the control word
`define CFC_CONTROL_RST 32'h00000000

`endif

//--- cfc_pkg.sv
package cfc_pkg;

  // One filter slot, enable bit first
  typedef struct packed {
    logic on;
    logic [1:0] mask;
    logic [4:0] fifo;
  } cfc_slot_t;

  // Whole control word, slot 3 at the top byte
  typedef struct packed {
    cfc_slot_t [3:0] slot;
  } cfc_word_t;

  // Decoded view of one filter for the matcher
  typedef struct packed {
    logic on;
    logic [3:0] mask_hot;
    logic [4:0] fifo;
  } cfc_sel_t;

  // Module state
  typedef struct packed {
    cfc_word_t ctrl;
    logic [31:0] rdata;
    logic [3:0] blocked;
  } cfc_state_t;

endpackage : cfc_pkg

//--- cfc_filter_ctrl.sv
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "cfc_params.svh"
// How it works
// - Slot top bit enables the filter; clear means the filter is ignored.
// - Two mask bits pick acceptance mask 0 to 3 by value.
// - Five fifo bits pick receive FIFO 0 to 31 by value.
// - Writes to a slot are ignored while its enable bit is one.
// - Slots top at bits 31, 23, 15, 7: enable, mask, fifo order.
module cfc_filter_ctrl
  import cfc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output cfc_sel_t [3:0] filter_sel
);

  cfc_state_t s_q;
  cfc_state_t s_d;

  // Mask value to one-hot choice of four masks
  function automatic logic [3:0] mask_decode(input logic [1:0] m);
    logic [3:0] r;
    r = 4'h0;
    r[m] = 1'b1;
    return r;
  endfunction : mask_decode

  // Next-state logic
  always_comb begin
    cfc_slot_t nw;
    nw = '0;
    s_d = s_q;
    s_d.rdata = 32'h00000000;
    s_d.blocked = 4'h0;
    if (wr && addr == `CFC_OFS_CONTROL) begin
      for (int i = 0; i < 4; i++) begin
        nw = wdata[i*8 +: 8];
        if (s_q.ctrl.slot[i].on) begin
          s_d.blocked[i] = 1'b1;
        end else begin
          s_d.ctrl.slot[i] = nw;
        end
      end
    end
    if (rd) begin
      if (addr == `CFC_OFS_CONTROL) begin
        s_d.rdata = s_q.ctrl;
      end else if (addr == `CFC_OFS_STATUS) begin
        s_d.rdata = {28'h0000000, s_q.blocked};
      end else begin
        s_d.rdata = 32'h00000000;
      end
    end
    if (!rd) begin
      s_d.rdata = 32'h00000000;
    end
    if (!(wr && addr == `CFC_OFS_CONTROL)) begin
      s_d.blocked = s_q.blocked;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q.ctrl <= `CFC_CONTROL_RST;
      s_q.rdata <= 32'h00000000;
      s_q.blocked <= 4'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;

  // Per-filter view for the matcher
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      filter_sel[i].on = s_q.ctrl.slot[i].on;
      filter_sel[i].mask_hot = s_q.ctrl.slot[i].on ? mask_decode(s_q.ctrl.slot[i].mask) : 4'h0;
      filter_sel[i].fifo = s_q.ctrl.slot[i].fifo;
    end
  end

  a_locked_slot: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && s_q.ctrl.slot[3].on) |=> $stable(s_q.ctrl.slot[3]))
    else $error("slot 3 changed while enabled");
  a_free_slot: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[0].on) |=> s_q.ctrl.slot[0] == $past(wdata[7:0]))
    else $error("slot 0 write lost");
  a_top_slot: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[3].on) |=> filter_sel[3].on == $past(wdata[31]))
    else $error("enable bit misplaced");
  a_mask_pick: assert property (@(posedge clk) disable iff (!nrst)
    filter_sel[2].on |-> filter_sel[2].mask_hot == (4'h1 << s_q.ctrl.slot[2].mask))
    else $error("mask choice wrong");
  a_fifo_pick: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[1].on) |=> filter_sel[1].fifo == $past(wdata[12:8]))
    else $error("fifo choice wrong");
  a_reset_clear: assert property (@(posedge clk) !nrst |=> s_q.ctrl == 32'h00000000)
    else $error("control not cleared by reset");
  a_read_back: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == `CFC_OFS_CONTROL) |=> rdata == $past(s_q.ctrl))
    else $error("read data wrong");
  a_idle_read: assert property (@(posedge clk) disable iff (!nrst)
    !rd |=> rdata == 32'h00000000)
    else $error("read data without strobe");

  // Locked slots keep their byte whatever the write carries
  a_lock_slot0: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && s_q.ctrl.slot[0].on)
    |=> $stable(s_q.ctrl.slot[0]))
    else $error("slot 0 changed while enabled");
  a_lock_slot1: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && s_q.ctrl.slot[1].on)
    |=> $stable(s_q.ctrl.slot[1]))
    else $error("slot 1 changed while enabled");
  a_lock_slot2: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && s_q.ctrl.slot[2].on)
    |=> $stable(s_q.ctrl.slot[2]))
    else $error("slot 2 changed while enabled");

  // Free slots take their own byte of the write
  a_free_slot1: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[1].on)
    |=> s_q.ctrl.slot[1] == $past(wdata[15:8]))
    else $error("slot 1 write lost");
  a_free_slot2: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[2].on)
    |=> s_q.ctrl.slot[2] == $past(wdata[23:16]))
    else $error("slot 2 write lost");
  a_free_slot3: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[3].on)
    |=> s_q.ctrl.slot[3] == $past(wdata[31:24]))
    else $error("slot 3 write lost");

  // Enable sits at the top bit of each byte
  a_on_slot0: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[0].on)
    |=> filter_sel[0].on == $past(wdata[7]))
    else $error("slot 0 enable misplaced");
  a_on_slot1: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[1].on)
    |=> filter_sel[1].on == $past(wdata[15]))
    else $error("slot 1 enable misplaced");
  a_on_slot2: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[2].on)
    |=> filter_sel[2].on == $past(wdata[23]))
    else $error("slot 2 enable misplaced");

  // Each mask code picks its own mask
  a_mask_code0: assert property (@(posedge clk) disable iff (!nrst)
    (filter_sel[0].on && s_q.ctrl.slot[0].mask == 2'h0)
    |-> filter_sel[0].mask_hot == 4'h1)
    else $error("mask code 0 wrong");
  a_mask_code3: assert property (@(posedge clk) disable iff (!nrst)
    (filter_sel[1].on && s_q.ctrl.slot[1].mask == 2'h3)
    |-> filter_sel[1].mask_hot == 4'h8)
    else $error("mask code 3 wrong");
  a_mask_code1: assert property (@(posedge clk) disable iff (!nrst)
    (filter_sel[2].on && s_q.ctrl.slot[2].mask == 2'h1)
    |-> filter_sel[2].mask_hot == 4'h2)
    else $error("mask code 1 wrong");
  a_mask_code2: assert property (@(posedge clk) disable iff (!nrst)
    (filter_sel[3].on && s_q.ctrl.slot[3].mask == 2'h2)
    |-> filter_sel[3].mask_hot == 4'h4)
    else $error("mask code 2 wrong");

  // A filter that is off selects no mask at all
  a_off_slot0: assert property (@(posedge clk) disable iff (!nrst)
    !filter_sel[0].on
    |-> filter_sel[0].mask_hot == 4'h0)
    else $error("slot 0 off but mask chosen");
  a_off_slot1: assert property (@(posedge clk) disable iff (!nrst)
    !filter_sel[1].on
    |-> filter_sel[1].mask_hot == 4'h0)
    else $error("slot 1 off but mask chosen");
  a_off_slot2: assert property (@(posedge clk) disable iff (!nrst)
    !filter_sel[2].on
    |-> filter_sel[2].mask_hot == 4'h0)
    else $error("slot 2 off but mask chosen");
  a_off_slot3: assert property (@(posedge clk) disable iff (!nrst)
    !filter_sel[3].on
    |-> filter_sel[3].mask_hot == 4'h0)
    else $error("slot 3 off but mask chosen");

  // Disabling write leaves the view without a mask
  a_dis_slot0: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[0].on && !wdata[7])
    |=> filter_sel[0].mask_hot == 4'h0)
    else $error("slot 0 disable write wrong");
  a_dis_slot1: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[1].on && !wdata[15])
    |=> filter_sel[1].mask_hot == 4'h0)
    else $error("slot 1 disable write wrong");
  a_dis_slot2: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[2].on && !wdata[23])
    |=> filter_sel[2].mask_hot == 4'h0)
    else $error("slot 2 disable write wrong");
  a_dis_slot3: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[3].on && !wdata[31])
    |=> filter_sel[3].mask_hot == 4'h0)
    else $error("slot 3 disable write wrong");

  // Fifo field lands at the low five bits of each byte
  a_fifo_slot0: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[0].on)
    |=> filter_sel[0].fifo == $past(wdata[4:0]))
    else $error("slot 0 fifo wrong");
  a_fifo_slot2: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[2].on)
    |=> filter_sel[2].fifo == $past(wdata[20:16]))
    else $error("slot 2 fifo wrong");
  a_fifo_slot3: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[3].on)
    |=> filter_sel[3].fifo == $past(wdata[28:24]))
    else $error("slot 3 fifo wrong");

  // Status flags a refused slot on every control write
  a_refuse_flag0: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && s_q.ctrl.slot[0].on)
    |=> s_q.blocked[0])
    else $error("slot 0 refusal not flagged");
  a_refuse_flag1: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && s_q.ctrl.slot[1].on)
    |=> s_q.blocked[1])
    else $error("slot 1 refusal not flagged");
  a_refuse_flag2: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && s_q.ctrl.slot[2].on)
    |=> s_q.blocked[2])
    else $error("slot 2 refusal not flagged");
  a_refuse_flag3: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && s_q.ctrl.slot[3].on)
    |=> s_q.blocked[3])
    else $error("slot 3 refusal not flagged");

  // Accepted slots clear their status flag
  a_accept_flag0: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[0].on)
    |=> !s_q.blocked[0])
    else $error("slot 0 flag stuck");
  a_accept_flag1: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[1].on)
    |=> !s_q.blocked[1])
    else $error("slot 1 flag stuck");
  a_accept_flag2: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[2].on)
    |=> !s_q.blocked[2])
    else $error("slot 2 flag stuck");
  a_accept_flag3: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `CFC_OFS_CONTROL && !s_q.ctrl.slot[3].on)
    |=> !s_q.blocked[3])
    else $error("slot 3 flag stuck");

  // Status holds between control writes
  a_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
    !(wr && addr == `CFC_OFS_CONTROL)
    |=> $stable(s_q.blocked))
    else $error("status changed without write");

  // Reset also clears status and read data
  a_reset_flags: assert property (@(posedge clk)
    !nrst
    |=> s_q.blocked == 4'h0)
    else $error("status not cleared by reset");
  a_reset_rdata: assert property (@(posedge clk)
    !nrst
    |=> rdata == 32'h00000000)
    else $error("read data not cleared by reset");

  // Status and unmapped reads
  a_status_read: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == `CFC_OFS_STATUS)
    |=> rdata == {28'h0000000, $past(s_q.blocked)})
    else $error("status read wrong");
  a_unmapped_read: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr != `CFC_OFS_CONTROL && addr != `CFC_OFS_STATUS)
    |=> rdata == 32'h00000000)
    else $error("unmapped read not zero");

endmodule : cfc_filter_ctrl

//--- tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [31:0] rdata;
  logic [39:0] fsel;
  int error_cnt = 0;
  int samples_checked = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  cfc_filter_ctrl DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .filter_sel(fsel));
  // Compare and count
  task chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One write cycle
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  // One read cycle, data judged in the cycle after
  task rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rd_reg
  // Control word and filter view cleared after reset
  task t_reset;
    rd_reg(4'h0, 32'h0);
    chk(fsel, 40'h0);
  endtask : t_reset
  // All mask codes in a disabled slot
  task t_masks;
    for (int m = 0; m < 4; m++) begin
      wr_reg(4'h0, {8'h00, 1'h0, m[1:0], 5'h0A, 16'h0000});
      rd_reg(4'h0, {8'h00, 1'h0, m[1:0], 5'h0A, 16'h0000});
    end
  endtask : t_masks
  // Enable two slots, then try to clear all
  task t_lock;
    wr_reg(4'h0, 32'hDF2A6180);
    rd_reg(4'h0, 32'hDF2A6180);
    chk(fsel, {1'h1, 4'h4, 5'h1F, 1'h0, 4'h0, 5'h0A, 1'h0, 4'h0, 5'h01, 1'h1, 4'h1, 5'h00});
    wr_reg(4'h0, 32'h0);
    rd_reg(4'h0, 32'hDF000080);
    chk(fsel, {1'h1, 4'h4, 5'h1F, 20'h0, 1'h1, 4'h1, 5'h00});
    rd_reg(4'h1, 32'h9);
    rd_reg(4'hF, 32'h0);
  endtask : t_lock
  // Reset in mid-run frees locked slots, then enable two more mask codes
  task t_rst;
    @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    rd_reg(4'h0, 32'h0);
    rd_reg(4'h1, 32'h0);
    chk(fsel, 40'h0);
    wr_reg(4'h0, 32'h00A1F500);
    #1;
    chk(fsel, {10'h000, 1'h1, 4'h2, 5'h01, 1'h1, 4'h8, 5'h15, 10'h000});
  endtask : t_rst
  // Verdict
  task summarize;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    t_reset();
    t_masks();
    t_lock();
    t_rst();
    summarize();
  end
  // Hang guard
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule : tb
